/* File: pkg/ubr_pkg.sv */
// Package for the banked uart register slice: offsets, resets, fields
package ubr_pkg;
  // Word offsets inside every bank
  localparam logic [4:0] OFS_00 = 5'h00;
  localparam logic [4:0] OFS_04 = 5'h04;
  localparam logic [4:0] OFS_08 = 5'h08;
  localparam logic [4:0] OFS_0C = 5'h0c;
  localparam logic [4:0] OFS_10 = 5'h10;
  localparam logic [4:0] OFS_14 = 5'h14;
  localparam logic [4:0] OFS_18 = 5'h18;
  localparam logic [4:0] OFS_1C = 5'h1c;
  // Own offset for the line control word (bank 0)
  localparam logic [4:0] OFS_LINE_CTRL = 5'h0c;
  // Own offsets for irq status and mask (bank 1, read-only slots unused)
  localparam logic [4:0] OFS_EVT_STATUS = 5'h18;
  localparam logic [4:0] OFS_EVT_MASK = 5'h10;
  // Bank numbers
  localparam logic [1:0] BANK_COMPAT = 2'h0;
  localparam logic [1:0] BANK_WORK = 2'h1;
  localparam logic [1:0] BANK_CONFIG = 2'h2;
  localparam logic [1:0] BANK_BAUD = 2'h3;
  // Field positions
  localparam int BANK_LO = 5;
  localparam int BANK_HI = 6;
  localparam int LATCH_BIT = 7;
  // Reset values
  localparam logic [7:0] RST_IRQ_BANK = 8'h01;
  localparam logic [7:0] RST_GEN_A_LOW = 8'h02;
  localparam logic [7:0] RST_GEN_A_CFG = 8'h04;
  localparam logic [7:0] RST_GEN_B_LOW = 8'h05;
  localparam logic [7:0] RST_GEN_B_CFG = 8'h84;
  localparam logic [7:0] RST_INT_MODE = 8'h0c;
  localparam logic [7:0] RST_RX_IRQ_EN = 8'h1e;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Event bits
  localparam int EVT_TX_OVF = 0;
  localparam int EVT_RX_UNF = 1;
  localparam int EVT_RX_AVAIL = 2;
  localparam int EVT_W = 3;
  // Fifo depth
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  // Register access decode kinds
  typedef enum logic [2:0] {
    ACC_NONE = 3'h0,
    ACC_DATA = 3'h1,
    ACC_OTHER = 3'h2
  } ubr_acc_type;
endpackage : ubr_pkg

/* File: core/ubr_regs.sv */
// Banked uart register slice: data bytes, divisors, configuration banks
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module ubr_regs
  import ubr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Transmit byte stream out
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // Receive byte stream in
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  // Divisors and interrupt
  output logic [15:0] gen_a_divisor,
  output logic [15:0] gen_b_divisor,
  output logic irq
);
  import ubr_pkg::*;

  // Software-visible state
  logic [7:0] irq_and_bank_select;
  logic [7:0] line_control;
  logic [7:0] gen_a_divisor_low;
  logic [7:0] gen_a_divisor_high;
  logic [7:0] gen_b_divisor_low;
  logic [7:0] gen_b_divisor_high;
  logic [7:0] clock_source_config;
  logic [7:0] gen_a_config;
  logic [7:0] gen_b_config;
  logic [7:0] timer_irq_enables;
  logic [7:0] fifo_mode;
  logic [7:0] transmitter_mode;
  logic [7:0] internal_mode;
  logic [7:0] addr_ctrl_char_one;
  logic [7:0] rx_irq_enables;
  logic [7:0] receiver_mode;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_mask;
  // Receive fifo storage
  logic [7:0] rx_mem [FIFO_DEPTH];
  logic [PTR_W:0] rx_wp;
  logic [PTR_W:0] rx_rp;
  logic rx_empty;
  logic rx_full;
  // Decoded bank and latch
  logic [1:0] bank;
  logic latch;
  logic data_space;
  logic wr_data;
  logic rd_data;
  logic [31:0] next_rdata;
  // Event strobes raised in this cycle
  logic [EVT_W-1:0] evt_set;

  // Register hit check used for every decode except the config bank case statements and the baud bank read case
  function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
    hit = (a == o);
  endfunction : hit

  assign bank = irq_and_bank_select[BANK_HI:BANK_LO];
  assign latch = line_control[LATCH_BIT];
  assign data_space = ((bank == BANK_COMPAT) && !latch) || (bank == BANK_WORK);
  assign wr_data = reg_wr && hit(reg_addr, OFS_00) && data_space;
  assign rd_data = reg_rd && hit(reg_addr, OFS_00) && data_space;
  assign rx_empty = (rx_wp == rx_rp);
  assign rx_full = (rx_wp[PTR_W] != rx_rp[PTR_W]) && (rx_wp[PTR_W-1:0] == rx_rp[PTR_W-1:0]);
  assign rx_ready = !rx_full;
  assign gen_a_divisor = {gen_a_divisor_high, gen_a_divisor_low};
  assign gen_b_divisor = {gen_b_divisor_high, gen_b_divisor_low};
  // Level interrupt from unmasked sticky events
  assign irq = |(evt_status & evt_mask);

  // Shared irq/bank register; only bank bits writable
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      irq_and_bank_select <= RST_IRQ_BANK;
    else if (reg_wr && hit(reg_addr, OFS_08))
      irq_and_bank_select[BANK_HI:BANK_LO] <= reg_wdata[BANK_HI:BANK_LO];
  end

  // Bank 0 registers: line control and first divisor
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      line_control <= RST_ZERO;
      gen_a_divisor_low <= RST_GEN_A_LOW;
      gen_a_divisor_high <= RST_ZERO;
    end
    else if (reg_wr && bank == BANK_COMPAT)
    begin
      if (hit(reg_addr, OFS_LINE_CTRL))
        line_control <= reg_wdata[7:0];
      // divisor low byte, bit 7 msb
      if (hit(reg_addr, OFS_00) && latch)
        gen_a_divisor_low <= reg_wdata[7:0];
      if (hit(reg_addr, OFS_04) && latch)
        gen_a_divisor_high <= reg_wdata[7:0];
    end
  end

  // Configuration bank registers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      fifo_mode <= RST_ZERO;
      transmitter_mode <= RST_ZERO;
      internal_mode <= RST_INT_MODE;
      addr_ctrl_char_one <= RST_ZERO;
      rx_irq_enables <= RST_RX_IRQ_EN;
      receiver_mode <= RST_ZERO;
    end
    else if (reg_wr && bank == BANK_CONFIG)
    begin
      case (reg_addr)
        OFS_04: fifo_mode <= reg_wdata[7:0];
        OFS_0C: transmitter_mode <= reg_wdata[7:0];
        OFS_10: internal_mode <= reg_wdata[7:0];
        OFS_14: addr_ctrl_char_one <= reg_wdata[7:0];
        OFS_18: rx_irq_enables <= reg_wdata[7:0];
        OFS_1C: receiver_mode <= reg_wdata[7:0];
        // Offset 0 reserved, writes dropped
        default: ;
      endcase
    end
  end

  // Baud bank registers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      clock_source_config <= RST_ZERO;
      gen_a_config <= RST_GEN_A_CFG;
      gen_b_divisor_low <= RST_GEN_B_LOW;
      gen_b_divisor_high <= RST_ZERO;
      gen_b_config <= RST_GEN_B_CFG;
      timer_irq_enables <= RST_ZERO;
    end
    else if (reg_wr && bank == BANK_BAUD)
    begin
      if (hit(reg_addr, OFS_00))
      begin
        if (latch)
          gen_b_divisor_low <= reg_wdata[7:0];
        else
          clock_source_config <= reg_wdata[7:0];
      end
      if (hit(reg_addr, OFS_04))
      begin
        if (latch)
          gen_b_divisor_high <= reg_wdata[7:0];
        else
          gen_a_config <= reg_wdata[7:0];
      end
      if (hit(reg_addr, OFS_0C))
        gen_b_config <= reg_wdata[7:0];
      if (hit(reg_addr, OFS_18))
        timer_irq_enables <= reg_wdata[7:0];
    end
  end

  // Transmit byte holding; no reset so contents stay undefined
  always_ff @(posedge ref_clk)
  begin
    if (wr_data)
      tx_data <= reg_wdata[7:0];
  end

  // Transmit valid: one byte held until the fifo takes it
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      tx_valid <= 1'b0;
    else if (wr_data)
      tx_valid <= 1'b1;
    else if (tx_ready)
      tx_valid <= 1'b0;
  end

  // Receive fifo write side
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rx_wp <= '0;
    else if (rx_valid && !rx_full)
    begin
      rx_mem[rx_wp[PTR_W-1:0]] <= rx_data;
      rx_wp <= rx_wp + {{PTR_W{1'b0}}, 1'b1};
    end
  end

  // Receive fifo read side
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rx_rp <= '0;
    else if (rd_data && !rx_empty)
      rx_rp <= rx_rp + {{PTR_W{1'b0}}, 1'b1};
  end

  // Event strobes; kept combinational so the sticky flop sees them this edge
  always_comb
  begin
    evt_set = '0;
    evt_set[EVT_TX_OVF] = wr_data && tx_valid && !tx_ready;
    evt_set[EVT_RX_UNF] = rd_data && rx_empty;
    evt_set[EVT_RX_AVAIL] = rx_valid && !rx_full;
  end

  // Sticky events; set wins over write-one clear
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      evt_status <= '0;
    else if (reg_wr && bank == BANK_WORK && hit(reg_addr, OFS_EVT_STATUS))
      evt_status <= (evt_status & ~reg_wdata[EVT_W-1:0]) | evt_set;
    else
      evt_status <= evt_status | evt_set;
  end

  // Event mask register
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      evt_mask <= '0;
    else if (reg_wr && bank == BANK_WORK && hit(reg_addr, OFS_EVT_MASK))
      evt_mask <= reg_wdata[EVT_W-1:0];
  end

  // Read mux; narrow data in low bits, upper bits zero
  always_comb
  begin
    next_rdata = '0;
    case (bank)
      BANK_COMPAT:
      begin
        if (hit(reg_addr, OFS_00))
          next_rdata[7:0] = latch ? gen_a_divisor_low : rx_mem[rx_rp[PTR_W-1:0]];
        else if (hit(reg_addr, OFS_04) && latch)
          next_rdata[7:0] = gen_a_divisor_high;
        else if (hit(reg_addr, OFS_LINE_CTRL))
          next_rdata[7:0] = line_control;
      end
      BANK_WORK:
      begin
        if (hit(reg_addr, OFS_00))
          next_rdata[7:0] = rx_mem[rx_rp[PTR_W-1:0]];
        else if (hit(reg_addr, OFS_EVT_STATUS))
          next_rdata[EVT_W-1:0] = evt_status;
        else if (hit(reg_addr, OFS_EVT_MASK))
          next_rdata[EVT_W-1:0] = evt_mask;
      end
      BANK_CONFIG:
      begin
        case (reg_addr)
          OFS_04: next_rdata[7:0] = fifo_mode;
          OFS_0C: next_rdata[7:0] = transmitter_mode;
          OFS_10: next_rdata[7:0] = internal_mode;
          OFS_14: next_rdata[7:0] = addr_ctrl_char_one;
          OFS_18: next_rdata[7:0] = rx_irq_enables;
          OFS_1C: next_rdata[7:0] = receiver_mode;
          default: next_rdata = '0;
        endcase
      end
      default:
      begin
        case (reg_addr)
          OFS_00: next_rdata[7:0] = latch ? gen_b_divisor_low : clock_source_config;
          OFS_04: next_rdata[7:0] = latch ? gen_b_divisor_high : gen_a_config;
          OFS_0C: next_rdata[7:0] = gen_b_config;
          OFS_18: next_rdata[7:0] = timer_irq_enables;
          default: next_rdata = '0;
        endcase
      end
    endcase
    if (hit(reg_addr, OFS_08))
      next_rdata[7:0] = irq_and_bank_select;
    if (rd_data && rx_empty)
      next_rdata = '0;
  end

  // Registered read data, one cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      reg_rdata <= '0;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= '0;
  end

  // Assertions
  // push follows write
  a_tx_push_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_data |=> tx_valid && tx_data == $past(reg_wdata[7:0]))
    else $error("tx byte not pushed");
  a_rx_upper_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rd_data) |-> reg_rdata[31:8] == 24'h0)
    else $error("rx upper bits not zero");
  a_rx_pop_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_data && !rx_empty |=> rx_rp == $past(rx_rp) + 5'h01)
    else $error("rx read did not pop");
  a_bank_select_wr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr == OFS_08 |=> bank == $past(reg_wdata[BANK_HI:BANK_LO]))
    else $error("bank not updated");
  a_irq_bank_shared: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && reg_addr == OFS_08 |=> reg_rdata[7:0] == $past(irq_and_bank_select))
    else $error("irq bank register read wrong");
  a_div_latch_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && bank == BANK_COMPAT && !latch && reg_addr == OFS_00
      |=> $stable(gen_a_divisor_low))
    else $error("divisor written with latch clear");
  a_div_low_wr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && bank == BANK_COMPAT && latch && reg_addr == OFS_00
      |=> gen_a_divisor_low == $past(reg_wdata[7:0]))
    else $error("divisor low not written");
  a_baud_cfg_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && bank == BANK_BAUD && latch && reg_addr == OFS_00
      |=> $stable(clock_source_config))
    else $error("clock config written with latch set");
  a_cfg_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_rd && bank == BANK_CONFIG && reg_addr == OFS_00 |=> reg_rdata == 32'h0)
    else $error("reserved offset read nonzero");
  c_tx_push: cover property (@(posedge ref_clk) wr_data ##1 tx_ready);
  c_rx_pop: cover property (@(posedge ref_clk) rd_data && !rx_empty);
  c_bank_baud: cover property (@(posedge ref_clk) bank == BANK_BAUD && latch);
  c_irq: cover property (@(posedge ref_clk) irq);
endmodule : ubr_regs
`default_nettype wire

/* File: verification/ubr_far_side.sv */
// Far side model: transmit byte sink and receive byte source
`timescale 1ns/10ps
`default_nettype none
module ubr_far_side (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Transmit byte sink
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Receive byte source
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready
);
  // Stall switch, set by the bench
  logic tx_stall = 1'b0;
  // Last accepted byte and count
  logic [7:0] tx_last = 8'h00;
  int tx_count = 0;
  // Pending receive bytes, 32 at most
  logic [7:0] mem [0:31];
  int wr_ptr = 0;
  int rd_ptr = 0;
  // Inverted while idle, so a stale byte never passes for fresh data
  logic [7:0] last_rx = 8'h00;
  assign tx_ready = !tx_stall;
  assign rx_valid = (wr_ptr != rd_ptr);
  assign rx_data = rx_valid ? mem[rd_ptr[4:0]] : ~last_rx;
  // Take bytes on each handshake
  always @(posedge ref_clk)
  begin
    if (rst_n && tx_valid && tx_ready)
    begin
      tx_last <= tx_data;
      tx_count <= tx_count + 1;
    end
    if (rst_n && rx_valid && rx_ready)
    begin
      last_rx <= rx_data;
      rd_ptr <= rd_ptr + 1;
    end
  end
  // Queue one byte for the block to receive
  task automatic push_rx(input logic [7:0] b);
    mem[wr_ptr[4:0]] = b;
    wr_ptr = wr_ptr + 1;
  endtask : push_rx
endmodule : ubr_far_side
`default_nettype wire

/* File: verification/ubr_regs_test.sv */
// Self-checking bench for the banked uart register slice
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end
module ubr_regs_test;
  import ubr_pkg::*;
  // Design inputs
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  // Design outputs and stream wires
  logic [31:0] reg_rdata;
  logic [7:0] tx_data;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_ready;
  logic [15:0] gen_a_divisor;
  logic [15:0] gen_b_divisor;
  logic irq;
  // Counters
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  // Expected reset maps of bank 2 and bank 3
  logic [31:0] cfg_rst [8] = '{32'h0, 32'h0, 32'h41, 32'h0, 32'h0c, 32'h0, 32'h1e, 32'h0};
  logic [31:0] baud_rst [8] = '{32'h0, 32'h04, 32'h61, 32'h84, 32'h0, 32'h0, 32'h0, 32'h0};
  always #5 ref_clk = ~ref_clk;
  ubr_regs ubr_regs_inst (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .gen_a_divisor(gen_a_divisor),
    .gen_b_divisor(gen_b_divisor), .irq(irq));
  ubr_far_side ubr_far_side_inst (.ref_clk(ref_clk), .rst_n(rst_n), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready));
  // Verdict and end of run
  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // One-cycle write strobe
  // full word writes
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read strobe, data compared in the cycle after it
  task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("read data", exp, reg_rdata)
  endtask : rdc
  // Bank select, other bits written as zero
  task automatic bank(input logic [1:0] b);
    wr(OFS_08, 32'(b) << BANK_LO);
  endtask : bank
  // Latch bit through line control in bank 0
  task automatic latch(input logic v);
    bank(BANK_COMPAT);
    wr(OFS_LINE_CTRL, v ? 32'h80 : 32'h0);
  endtask : latch
  // Let registered outputs land
  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask : settle
  // Hang guard, far above the roughly 155 cycles needed
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  // Main sequence
  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(OFS_08, 32'h01);
    `CHK("gen a divisor", 16'h0002, gen_a_divisor)
    `CHK("gen b divisor", 16'h0005, gen_b_divisor)
    `CHK("rx ready", 1'b1, rx_ready)
    // Read data stands one cycle, then drops to zero
    settle();
    `CHK("read idle", 32'h0, reg_rdata)
    // Configuration bank: reset map, then write and read back
    bank(BANK_CONFIG);
    for (int i = 0; i < 8; i++)
      rdc(5'(i * 4), cfg_rst[i]);
    for (int i = 1; i < 8; i++)
      if (i != 2)
      begin
        wr(5'(i * 4), 32'h50 + i);
        rdc(5'(i * 4), 32'h50 + i);
      end
    // Baud bank with latch clear, reserved slot ignores writes
    bank(BANK_BAUD);
    for (int i = 0; i < 8; i++)
      rdc(5'(i * 4), baud_rst[i]);
    wr(OFS_10, 32'hff);
    rdc(OFS_10, 32'h0);
    // Latch set: second generator divisor bytes
    latch(1'b1);
    bank(BANK_BAUD);
    rdc(OFS_00, 32'h05);
    rdc(OFS_04, 32'h0);
    wr(OFS_00, 32'h34);
    wr(OFS_04, 32'h12);
    settle();
    `CHK("gen b divisor", 16'h1234, gen_b_divisor)
    latch(1'b0);
    bank(BANK_BAUD);
    rdc(OFS_00, 32'h0);
    rdc(OFS_04, 32'h04);
    // First generator low and high divisor bytes, no byte pushed meanwhile
    latch(1'b1);
    wr(OFS_00, 32'ha5);
    wr(OFS_04, 32'h01);
    settle();
    `CHK("gen a divisor", 16'h01a5, gen_a_divisor)
    rdc(OFS_00, 32'ha5);
    `CHK("tx count", 0, ubr_far_side_inst.tx_count)
    // Transmit from bank 0 and bank 1
    latch(1'b0);
    wr(OFS_00, 32'h5a);
    repeat (2) settle();
    `CHK("tx byte", 8'h5a, ubr_far_side_inst.tx_last)
    `CHK("gen a divisor", 16'h01a5, gen_a_divisor)
    bank(BANK_WORK);
    wr(OFS_00, 32'hc3);
    repeat (2) settle();
    `CHK("tx byte", 8'hc3, ubr_far_side_inst.tx_last)
    // Overwrite while the sink stalls
    ubr_far_side_inst.tx_stall <= 1'b1;
    wr(OFS_00, 32'h11);
    #1;
    `CHK("tx valid", 1'b1, tx_valid)
    wr(OFS_00, 32'h22);
    ubr_far_side_inst.tx_stall <= 1'b0;
    repeat (3) settle();
    `CHK("tx byte", 8'h22, ubr_far_side_inst.tx_last)
    `CHK("tx count", 3, ubr_far_side_inst.tx_count)
    // Receive order, pop on read, empty read
    ubr_far_side_inst.push_rx(8'h3c);
    ubr_far_side_inst.push_rx(8'h81);
    repeat (3) settle();
    rdc(OFS_00, 32'h3c);
    rdc(OFS_00, 32'h81);
    rdc(OFS_00, 32'h0);
    // Sticky events, mask and one-to-clear
    rdc(OFS_EVT_STATUS, 32'h07);
    `CHK("irq", 1'b0, irq)
    wr(OFS_EVT_MASK, 32'h02);
    settle();
    `CHK("irq", 1'b1, irq)
    wr(OFS_EVT_STATUS, 32'h02);
    settle();
    `CHK("irq", 1'b0, irq)
    rdc(OFS_EVT_STATUS, 32'h05);
    wr(OFS_EVT_MASK, 32'h05);
    settle();
    `CHK("irq", 1'b1, irq)
    wr(OFS_EVT_STATUS, 32'h05);
    settle();
    `CHK("irq", 1'b0, irq)
    rdc(OFS_EVT_STATUS, 32'h0);
    tally_and_finish();
  end
endmodule : ubr_regs_test
`default_nettype wire
